/* File: design/sswc_defs.svh */
`ifndef SSWC_DEFS_SVH
`define SSWC_DEFS_SVH

// ----------------------------------------
// Timing
// ----------------------------------------
// Standby clock rate in hertz.
`define SSWC_CLK_HZ 20000000
// Power switch hold time, in seconds, that turns a press into a forced off.
`define SSWC_LONG_PRESS_S 4

// ----------------------------------------
// Register map
// ----------------------------------------
// Byte address width of the register port.
`define SSWC_AXI_AW 4
`define SSWC_ADDR_CTRL 4'h0
`define SSWC_ADDR_SLEEP 4'h4
`define SSWC_ADDR_STATUS 4'h8

// Control register width, reset value and bit positions.
`define SSWC_CTRL_W 4
`define SSWC_CTRL_RST 4'h0
`define SSWC_CTRL_S5_WAKE 0
`define SSWC_CTRL_PCI_WAKE 1
`define SSWC_CTRL_RING_UNMASK 2
`define SSWC_CTRL_SLEEP_S3 3

// Sleep command codes in bits 1:0 of the sleep register.
`define SSWC_SLP_S1 2'h0
`define SSWC_SLP_S3 2'h1
`define SSWC_SLP_S4 2'h2

// Status register field positions.
`define SSWC_STAT_ST_W 3
`define SSWC_STAT_SRC_LSB 8
`define SSWC_STAT_PME_BIT 14
`define SSWC_STAT_WAKE_BIT 16

// Bus answers.
`define SSWC_RESP_OKAY 2'h0
`define SSWC_RESP_SLVERR 2'h2

// Restore policy codes on the stored configuration pins.
`define SSWC_POL_LAST 2'h0
`define SSWC_POL_OFF 2'h1
`define SSWC_POL_ON 2'h2

`endif

/* File: design/sswc_pkg.sv */
package sswc_pkg;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  // System states, Gray coded along off, on, light sleep, suspend, hibernate.
  typedef enum logic [2:0] {
    SSWC_S5 = 3'h0,
    SSWC_S0 = 3'h1,
    SSWC_S1 = 3'h3,
    SSWC_S3 = 3'h2,
    SSWC_S4 = 3'h6
  } sswc_state_type;

  // Register select produced by the address decoder.
  typedef enum logic [1:0] {
    SSWC_SEL_CTRL = 2'h0,
    SSWC_SEL_SLEEP = 2'h1,
    SSWC_SEL_STATUS = 2'h2,
    SSWC_SEL_NONE = 2'h3
  } sswc_sel_type;

  // Active-high wake sources other than the PCI event line.
  typedef struct packed {
    logic kbd;
    logic usb;
    logic ring;
    logic lan;
    logic rtc;
    logic pwr_btn;
  } sswc_wake_type;

  // Board power controls.
  typedef struct packed {
    logic ps_on;
    logic fan_on;
    logic led_green;
    logic led_amber;
    logic led_single;
    logic mem_hold;
    logic standby_only;
    logic last_on;
    logic cold_boot;
    logic warm_resume;
  } sswc_pwr_type;

endpackage

/* File: design/sswc_sync.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Two-stage level synchroniser
// ----------------------------------------
module sswc_sync #(
  parameter int W = 7
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Raw levels and their synchronised copies.
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // The first stage may go metastable, so only the second stage reads it.
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stab;
  } sswc_sync_state_type;

  sswc_sync_state_type r;
  sswc_sync_state_type next_r;

  // Shift the levels one stage per edge.
  always_comb begin
    next_r = r;
    next_r.meta = d;
    next_r.stab = r.meta;
  end

  // Register the state.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign q = r.stab;

endmodule

`default_nettype wire

/* File: design/sswc_press_timer.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Power switch press timer
// ----------------------------------------
module sswc_press_timer #(
  parameter int unsigned LONG_CYC = 80000000
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Synchronised switch level, high while pressed.
  input wire logic btn,
  // One-cycle results of a press.
  output logic short_press,
  output logic long_press
);

  localparam int CW = $clog2(LONG_CYC + 1);

  // Hold counter, a flag that the long result was already given, and pulses.
  typedef struct packed {
    logic [CW-1:0] cnt;
    logic held_long;
    logic short_p;
    logic long_p;
  } sswc_press_state_type;

  sswc_press_state_type r;
  sswc_press_state_type next_r;

  // A long result fires while the switch is still held, so the forced off
  // does not wait for release; the release after it gives nothing more.
  always_comb begin
    next_r = r;
    next_r.short_p = 1'b0;
    next_r.long_p = 1'b0;
    if (btn) begin
      if (!r.held_long) begin
        if (r.cnt == CW'(LONG_CYC - 1)) begin
          next_r.long_p = 1'b1;
          next_r.held_long = 1'b1;
        end else begin
          next_r.cnt = CW'(r.cnt + 1'b1);
        end
      end
    end else begin
      // Release of a press that never reached the long mark.
      next_r.short_p = (r.cnt != '0) && !r.held_long;
      next_r.cnt = '0;
      next_r.held_long = 1'b0;
    end
  end

  // Register the state.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign short_press = r.short_p;
  assign long_press = r.long_p;

endmodule

`default_nettype wire

/* File: design/sswc_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sswc_defs.svh"

// How it works
// - Switch or alarm wakes any sleep state.
// - Modem wake only from S1 or S3.
// - S5 network and PCI wake need option.
// - PCI event with enable wakes sleep.
// - USB activity wakes only S1, S3.
// - Keyboard or mouse wakes only S1, S3.
// - Modem ring resumes from S1 or S3.
// - Network wake signal powers system up.
// - Fans on in S0, S1 only.
// - Restore prior on or off after loss.
// - Only wake logic powered in S3-S5.
// - S3 keeps context in main memory.
// - Leaving S5 always cold boots.
// - S3: supply off, amber or dark LED.
// - Short press toggles on and sleep.
// - Long press forces soft off.
module sswc_top #(
  parameter int unsigned LONG_PRESS_CYC = `SSWC_LONG_PRESS_S * `SSWC_CLK_HZ
) (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // AXI4-Lite write channels.
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [`SSWC_AXI_AW-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read channels.
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [`SSWC_AXI_AW-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Wake sources.
  input wire sswc_pkg::sswc_wake_type wake_src,
  input wire logic pci_pme_n,
  // Stored restore policy and last power state.
  input wire logic [1:0] cfg_policy,
  input wire logic cfg_last_on,
  // Board power controls.
  output var sswc_pkg::sswc_pwr_type pwr
);
  import sswc_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  // Everything this module remembers outside the synchroniser and press timer, bus slave included.
  typedef struct packed {
    sswc_state_type st;
    logic restore;
    logic wake;
    logic [`SSWC_CTRL_W-1:0] ctrl;
    sswc_pwr_type pwr;
    logic aw_rdy;
    logic aw_held;
    logic [`SSWC_AXI_AW-1:0] aw_addr;
    logic w_rdy;
    logic w_held;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic ar_rdy;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } sswc_top_state_type;

  sswc_top_state_type r;
  sswc_top_state_type next_r;

  sswc_wake_type src_s; // Synchronised wake sources.
  logic pme_s; // Synchronised PCI event, active high.
  logic short_p; // Short press pulse.
  logic long_p; // Long press pulse.
  logic sleep_go; // A sleep command was written this cycle.
  logic light; // Current state is S1 or S3.

  // ----------------------------------------
  // Input conditioning
  // ----------------------------------------
  // The PCI event line is inverted ahead of the first stage, never after it.
  sswc_sync #(
    .W($bits(sswc_wake_type) + 1)
  ) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .d({~pci_pme_n, wake_src}),
    .q({pme_s, src_s})
  );

  // Press length decides between toggling and forcing off.
  sswc_press_timer #(
    .LONG_CYC(LONG_PRESS_CYC)
  ) u_press (
    .core_clk(core_clk),
    .srst(srst),
    .btn(src_s.pwr_btn),
    .short_press(short_p),
    .long_press(long_p)
  );

  // ----------------------------------------
  // Decoders
  // ----------------------------------------
  // Map a byte address to a register.
  function automatic sswc_sel_type reg_sel(input logic [`SSWC_AXI_AW-1:0] a);
    case (a)
      `SSWC_ADDR_CTRL: reg_sel = SSWC_SEL_CTRL;
      `SSWC_ADDR_SLEEP: reg_sel = SSWC_SEL_SLEEP;
      `SSWC_ADDR_STATUS: reg_sel = SSWC_SEL_STATUS;
      default: reg_sel = SSWC_SEL_NONE;
    endcase
  endfunction

  // Wake matrix: which source may leave which state. The switch is not
  // here; its press length is judged by the timer first.
  function automatic logic wake_ok(input sswc_state_type st,
                                   input logic [`SSWC_CTRL_W-1:0] c,
                                   input sswc_wake_type s,
                                   input logic pme);
    logic lt;
    logic deep;
    lt = (st == SSWC_S1) || (st == SSWC_S3);
    deep = lt || (st == SSWC_S4) || ((st == SSWC_S5) && c[`SSWC_CTRL_S5_WAKE]);
    wake_ok = (s.rtc && (st != SSWC_S0))
            | (s.lan && deep)
            | (pme && c[`SSWC_CTRL_PCI_WAKE] && deep)
            | (s.ring && lt && c[`SSWC_CTRL_RING_UNMASK])
            | (s.usb && lt)
            | (s.kbd && lt);
  endfunction

  assign light = (r.st == SSWC_S1) || (r.st == SSWC_S3);

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  // Bus slave, wake request, state machine and power outputs in one pass.
  always_comb begin
    next_r = r;
    sleep_go = 1'b0;
    next_r.pwr.cold_boot = 1'b0;
    next_r.pwr.warm_resume = 1'b0;

    // Address and data are taken in either order and held until both exist.
    if (s_axi_awvalid && r.aw_rdy) begin
      next_r.aw_held = 1'b1;
      next_r.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && r.w_rdy) begin
      next_r.w_held = 1'b1;
      next_r.w_data = s_axi_wdata;
      next_r.w_strb = s_axi_wstrb;
    end
    if (r.bvalid && s_axi_bready) begin
      next_r.bvalid = 1'b0;
    end
    // A write completes only once the previous answer has been taken.
    if (r.aw_held && r.w_held && !r.bvalid) begin
      next_r.aw_held = 1'b0;
      next_r.w_held = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = `SSWC_RESP_OKAY;
      case (reg_sel(r.aw_addr))
        SSWC_SEL_CTRL: begin
          if (r.w_strb[0]) begin
            next_r.ctrl = r.w_data[`SSWC_CTRL_W-1:0];
          end
        end
        SSWC_SEL_SLEEP: begin
          sleep_go = r.w_strb[0];
        end
        SSWC_SEL_STATUS: begin
          // Read-only; the write is accepted and dropped.
        end
        default: begin
          next_r.bresp = `SSWC_RESP_SLVERR;
        end
      endcase
    end
    next_r.aw_rdy = !next_r.aw_held;
    next_r.w_rdy = !next_r.w_held;

    // Reads answer one cycle after the address is taken.
    if (r.rvalid && s_axi_rready) begin
      next_r.rvalid = 1'b0;
    end
    if (s_axi_arvalid && r.ar_rdy) begin
      next_r.rvalid = 1'b1;
      next_r.rresp = `SSWC_RESP_OKAY;
      next_r.rdata = '0;
      case (reg_sel(s_axi_araddr))
        SSWC_SEL_CTRL: begin
          next_r.rdata[`SSWC_CTRL_W-1:0] = r.ctrl;
        end
        SSWC_SEL_SLEEP: begin
          // Command register reads as zero.
        end
        SSWC_SEL_STATUS: begin
          next_r.rdata[`SSWC_STAT_ST_W-1:0] = r.st;
          next_r.rdata[`SSWC_STAT_SRC_LSB +: $bits(sswc_wake_type)] = src_s;
          next_r.rdata[`SSWC_STAT_PME_BIT] = pme_s;
          next_r.rdata[`SSWC_STAT_WAKE_BIT] = r.wake;
        end
        default: begin
          next_r.rresp = `SSWC_RESP_SLVERR;
        end
      endcase
    end
    next_r.ar_rdy = !next_r.rvalid;

    // One registered request keeps the state machine off raw pin timing.
    next_r.wake = wake_ok(r.st, r.ctrl, src_s, pme_s);

    // The first cycle after reset applies the stored restore policy.
    if (r.restore) begin
      next_r.restore = 1'b0;
      if ((cfg_policy == `SSWC_POL_ON) ||
          ((cfg_policy != `SSWC_POL_OFF) && cfg_last_on)) begin
        next_r.st = SSWC_S0;
      end
    end else if (long_p && (r.st != SSWC_S5)) begin
      next_r.st = SSWC_S5;
    end else if (short_p) begin
      case (r.st)
        SSWC_S5: next_r.st = SSWC_S0;
        SSWC_S0: next_r.st = r.ctrl[`SSWC_CTRL_SLEEP_S3] ? SSWC_S3 : SSWC_S1;
        default: next_r.st = SSWC_S0;
      endcase
    end else if (r.wake && (r.st != SSWC_S0)) begin
      next_r.st = SSWC_S0;
    end else if (sleep_go && (r.st == SSWC_S0)) begin
      case (r.w_data[1:0])
        `SSWC_SLP_S1: next_r.st = SSWC_S1;
        `SSWC_SLP_S3: next_r.st = SSWC_S3;
        `SSWC_SLP_S4: next_r.st = SSWC_S4;
        default: next_r.st = SSWC_S5;
      endcase
    end

    // Outputs follow the new state, so they line up with it cycle for cycle.
    next_r.pwr.ps_on = (next_r.st == SSWC_S0) || (next_r.st == SSWC_S1);
    next_r.pwr.fan_on = (next_r.st == SSWC_S0) || (next_r.st == SSWC_S1);
    next_r.pwr.led_green = (next_r.st == SSWC_S0) || (next_r.st == SSWC_S1);
    next_r.pwr.led_amber = (next_r.st == SSWC_S3);
    next_r.pwr.led_single = (next_r.st == SSWC_S0) || (next_r.st == SSWC_S1);
    next_r.pwr.mem_hold = (next_r.st == SSWC_S3);
    next_r.pwr.standby_only = !next_r.pwr.ps_on;
    next_r.pwr.last_on = next_r.st inside {SSWC_S0, SSWC_S1, SSWC_S3};
    if (next_r.st == SSWC_S0) begin
      // Disk and soft-off exits rebuild everything; S1 and S3 pick up context.
      next_r.pwr.cold_boot = r.st inside {SSWC_S4, SSWC_S5};
      next_r.pwr.warm_resume = r.st inside {SSWC_S1, SSWC_S3};
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Synchronous reset lands in soft off with the restore step pending.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      r <= '0;
      r.st <= SSWC_S5;
      r.restore <= 1'b1;
      r.ctrl <= `SSWC_CTRL_RST;
    end else begin
      r <= next_r;
    end
  end

  assign s_axi_awready = r.aw_rdy;
  assign s_axi_wready = r.w_rdy;
  assign s_axi_bvalid = r.bvalid;
  assign s_axi_bresp = r.bresp;
  assign s_axi_arready = r.ar_rdy;
  assign s_axi_rvalid = r.rvalid;
  assign s_axi_rdata = r.rdata;
  assign s_axi_rresp = r.rresp;
  assign pwr = r.pwr;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  localparam sswc_wake_type RING_ONLY = '{ring: 1'b1, default: 1'b0};
  localparam sswc_wake_type LAN_ONLY = '{lan: 1'b1, default: 1'b0};
  localparam sswc_wake_type USB_ONLY = '{usb: 1'b1, default: 1'b0};

  // A sleeping system with a quiet switch sees the alarm.
  sequence s_alarm_asleep;
    (r.st != SSWC_S0) && src_s.rtc && !short_p && !long_p && !r.restore;
  endsequence
  sequence s_wake_then_on;
    r.wake ##1 (r.st == SSWC_S0);
  endsequence

  property p_alarm_wake;
    s_alarm_asleep |=> s_wake_then_on;
  endproperty
  a_alarm_wake: assert property (p_alarm_wake) else $error("alarm did not wake");

  property p_ring_deep;
    (r.st inside {SSWC_S4, SSWC_S5}) && (src_s == RING_ONLY) && !pme_s |=> !r.wake;
  endproperty
  a_ring_deep: assert property (p_ring_deep) else $error("ring woke deep sleep");

  property p_lan_s5;
    (r.st == SSWC_S5) && !r.ctrl[`SSWC_CTRL_S5_WAKE] && (src_s == LAN_ONLY) && !pme_s
      |=> !r.wake;
  endproperty
  a_lan_s5: assert property (p_lan_s5) else $error("network woke S5 while gated");

  property p_pme_wake;
    (r.st inside {SSWC_S1, SSWC_S3, SSWC_S4}) && pme_s && r.ctrl[`SSWC_CTRL_PCI_WAKE] |=> r.wake;
  endproperty
  a_pme_wake: assert property (p_pme_wake) else $error("PCI event did not wake");

  property p_usb_deep;
    (r.st == SSWC_S4) && (src_s == USB_ONLY) && !pme_s |=> !r.wake;
  endproperty
  a_usb_deep: assert property (p_usb_deep) else $error("USB woke S4");

  property p_kbd_light;
    light && src_s.kbd |=> r.wake;
  endproperty
  a_kbd_light: assert property (p_kbd_light) else $error("keyboard did not wake");

  property p_fan_off;
    (r.st inside {SSWC_S3, SSWC_S4, SSWC_S5}) |-> !pwr.fan_on && !pwr.ps_on;
  endproperty
  a_fan_off: assert property (p_fan_off) else $error("fan or supply on asleep");

  property p_amber;
    $rose(r.st == SSWC_S3) |-> pwr.led_amber && !pwr.led_single && pwr.mem_hold;
  endproperty
  a_amber: assert property (p_amber) else $error("S3 indication wrong");

  property p_cold;
    (r.st == SSWC_S5) ##1 (r.st == SSWC_S0) |-> pwr.cold_boot && !pwr.warm_resume;
  endproperty
  a_cold: assert property (p_cold) else $error("S5 exit without cold boot");

  property p_short_on;
    short_p && (r.st == SSWC_S5) && !r.restore |=> (r.st == SSWC_S0);
  endproperty
  a_short_on: assert property (p_short_on) else $error("short press did not power on");

  property p_long_off;
    long_p && (r.st != SSWC_S5) && !r.restore |=> (r.st == SSWC_S5) [*2];
  endproperty
  a_long_off: assert property (p_long_off) else $error("long press did not force off");

  property p_reset_off;
    $fell(srst) |-> (r.st == SSWC_S5) && r.restore && !pwr.ps_on;
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("reset did not land in off");

endmodule

`default_nettype wire

/* File: verification/sswc_wake_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------
// Far side: wake sources and power supply
// ----------------------------------------
module sswc_wake_model (
  // Clock and reset.
  input wire logic core_clk,
  input wire logic srst,
  // Requests from the bench and the supply command.
  input wire sswc_pkg::sswc_wake_type want,
  input wire logic pme_want,
  input wire logic ps_on,
  // Lines into the block and the main rail.
  output var sswc_pkg::sswc_wake_type wake_src,
  output logic pci_pme_n,
  output logic rail_main
);
  import sswc_pkg::*;

  // Sources move just after an edge, one cycle behind the request.
  always_ff @(posedge core_clk) begin
    if (srst) begin
      wake_src <= '0;
      pci_pme_n <= 1'h1;
    end else begin
      wake_src <= want;
      pci_pme_n <= !pme_want;
    end
  end

  // The supply keeps only standby power while told off.
  always_ff @(posedge core_clk) begin
    rail_main <= ps_on;
  end
endmodule

`default_nettype wire

/* File: verification/sleep_state_wake_control_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none
`include "sswc_defs.svh"

module sleep_state_wake_control_tb_top;
  import sswc_pkg::*;

  // ----------------------------------------
  // Bench signals
  // ----------------------------------------
  // A short long-press count keeps the run brief.
  localparam int unsigned LONG = 20;
  // Wake source masks in the order kbd, usb, ring, lan, rtc, switch.
  localparam logic [5:0] W_KBD = 6'h20;
  localparam logic [5:0] W_USB = 6'h10;
  localparam logic [5:0] W_RING = 6'h08;
  localparam logic [5:0] W_LAN = 6'h04;
  localparam logic [5:0] W_RTC = 6'h02;
  localparam logic [5:0] W_BTN = 6'h01;
  logic core_clk = 1'h0;
  logic srst = 1'h1;
  logic s_axi_awvalid = 1'h0;
  logic s_axi_wvalid = 1'h0;
  logic s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0;
  logic s_axi_rready = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0;
  logic [3:0] s_axi_araddr = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [1:0] cfg_policy = 2'h0;
  logic cfg_last_on = 1'h0;
  sswc_wake_type want = '0;
  sswc_wake_type wake_src;
  logic pme_want = 1'h0;
  logic pci_pme_n, rail_main, warm, cold;
  sswc_pwr_type pwr;
  int n_mismatch = 0;
  int num_checks = 0;

  // Standby clock at 20 MHz.
  always #25 core_clk = ~core_clk;

  sswc_top #(.LONG_PRESS_CYC(LONG)) sswc_top_i (.core_clk, .srst, .s_axi_awvalid,
    .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .wake_src, .pci_pme_n,
    .cfg_policy, .cfg_last_on, .pwr);
  sswc_wake_model sswc_wake_model_i (.core_clk, .srst, .want, .pme_want,
    .ps_on(pwr.ps_on), .wake_src, .pci_pme_n, .rail_main);

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  // Prints the counts and the verdict, then ends the run.
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic fail(input string m);
    n_mismatch++;
    $display("unexpected at %0t: %s", $time, m);
  endtask

  // Compares a plain value with case equality.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    num_checks++;
    if (got !== exp) fail(m);
  endtask

  // Write: both channels offered together, each dropped once taken.
  task automatic axw(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ad = 1'h0;
    logic wd = 1'h0;
    @(posedge core_clk);
    s_axi_awvalid <= 1'h1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'h1;
    s_axi_wdata <= d;
    s_axi_bready <= 1'h1;
    forever begin
      @(posedge core_clk);
      if (!ad && s_axi_awready) begin
        ad = 1'h1;
        s_axi_awvalid <= 1'h0;
      end
      if (!wd && s_axi_wready) begin
        wd = 1'h1;
        s_axi_wvalid <= 1'h0;
      end
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'h0;
        break;
      end
    end
  endtask

  task automatic axr(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ad = 1'h0;
    @(posedge core_clk);
    s_axi_arvalid <= 1'h1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'h1;
    forever begin
      @(posedge core_clk);
      if (!ad && s_axi_arready) begin
        ad = 1'h1;
        s_axi_arvalid <= 1'h0;
      end
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'h0;
        break;
      end
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [1:0] r;
    axw(a, d, r);
    chk(r, `SSWC_RESP_OKAY, "write answer");
  endtask

  // Reads the state code back through the status register.
  task automatic chk_st(input sswc_state_type e, input string m);
    logic [31:0] d;
    logic [1:0] r;
    axr(`SSWC_ADDR_STATUS, d, r);
    num_checks++;
    if (d[2:0] !== e) fail(m);
  endtask

  // Holds a source for some cycles, then watches for the resume pulses.
  task automatic wk(input logic [5:0] m, input logic p, input int hold);
    warm = 1'h0;
    cold = 1'h0;
    @(posedge core_clk);
    want <= m;
    pme_want <= p;
    repeat (hold) @(posedge core_clk);
    want <= '0;
    pme_want <= 1'h0;
    repeat (12) begin
      @(posedge core_clk);
      #1;
      warm |= pwr.warm_resume;
      cold |= pwr.cold_boot;
    end
  endtask

  // Reset held four cycles with the given restore inputs.
  task automatic rst(input logic [1:0] p, input logic l);
    @(posedge core_clk);
    srst <= 1'h1;
    cfg_policy <= p;
    cfg_last_on <= l;
    repeat (4) @(posedge core_clk);
    srst <= 1'h0;
    repeat (3) @(posedge core_clk);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rst(`SSWC_POL_LAST, 1'h0);
    chk_st(SSWC_S5, "last off restore");
    chk(pwr.standby_only, 1'h1, "standby only");
    chk(pwr.last_on, 1'h0, "last state off");
    rst(`SSWC_POL_OFF, 1'h1);
    chk_st(SSWC_S5, "policy off");
    rst(`SSWC_POL_ON, 1'h0);
    chk_st(SSWC_S0, "policy on");
    rst(`SSWC_POL_LAST, 1'h1);
    chk_st(SSWC_S0, "last on restore");
    $display("test reset finished");
  endtask

  task automatic t_bus;
    logic [31:0] d;
    logic [1:0] r;
    axr(4'hC, d, r);
    chk(r, `SSWC_RESP_SLVERR, "read hole");
    axw(4'hC, 32'h0, r);
    chk(r, `SSWC_RESP_SLVERR, "write hole");
    axr(`SSWC_ADDR_CTRL, d, r);
    chk(d, 32'h0, "control reset");
    wr(`SSWC_ADDR_CTRL, 32'hF);
    axr(`SSWC_ADDR_CTRL, d, r);
    chk(d, 32'hF, "control readback");
    // A write with byte 0 unstrobed must leave the control bits alone.
    s_axi_wstrb <= 4'h0;
    wr(`SSWC_ADDR_CTRL, 32'h0);
    s_axi_wstrb <= 4'hF;
    axr(`SSWC_ADDR_CTRL, d, r);
    chk(d, 32'hF, "strobe off keeps control");
    wr(`SSWC_ADDR_STATUS, 32'h0);
    axr(`SSWC_ADDR_SLEEP, d, r);
    chk(d, 32'h0, "sleep reads zero");
    $display("test bus finished");
  endtask

  task automatic t_s3s1;
    wr(`SSWC_ADDR_CTRL, 32'h0);
    wr(`SSWC_ADDR_SLEEP, 32'h1);
    chk_st(SSWC_S3, "enter suspend");
    chk(pwr.led_amber, 1'h1, "amber");
    chk(pwr.led_single, 1'h0, "single dark");
    chk(pwr.ps_on, 1'h0, "supply off");
    chk(pwr.fan_on, 1'h0, "fan off");
    chk(pwr.mem_hold, 1'h1, "memory hold");
    chk(pwr.last_on, 1'h1, "last state on");
    chk(pwr.led_green, 1'h0, "green dark");
    chk(rail_main, 1'h0, "main rail");
    wk(W_USB, 1'h0, 3);
    chk_st(SSWC_S0, "usb wake");
    chk(warm, 1'h1, "warm resume");
    wr(`SSWC_ADDR_SLEEP, 32'h0);
    chk_st(SSWC_S1, "enter standby");
    chk(pwr.fan_on, 1'h1, "fan on");
    wk(W_KBD, 1'h0, 3);
    chk_st(SSWC_S0, "keyboard wake");
    $display("test sleep finished");
  endtask

  task automatic t_s4;
    logic [5:0] ign [3] = '{W_USB, W_KBD, W_RING};
    wr(`SSWC_ADDR_CTRL, 32'h4);
    wr(`SSWC_ADDR_SLEEP, 32'h2);
    for (int i = 0; i < 3; i++) begin
      wk(ign[i], 1'h0, 3);
      chk_st(SSWC_S4, "ignored in hibernate");
    end
    chk(pwr.fan_on, 1'h0, "fan off");
    wk(W_RTC, 1'h0, 3);
    chk_st(SSWC_S0, "alarm wake");
    wr(`SSWC_ADDR_CTRL, 32'h0);
    wr(`SSWC_ADDR_SLEEP, 32'h1);
    wk(W_RING, 1'h0, 3);
    chk_st(SSWC_S3, "masked ring");
    wr(`SSWC_ADDR_CTRL, 32'h4);
    wk(W_RING, 1'h0, 3);
    chk_st(SSWC_S0, "ring wake");
    $display("test hibernate finished");
  endtask

  task automatic t_pme_s5;
    wr(`SSWC_ADDR_CTRL, 32'h0);
    wr(`SSWC_ADDR_SLEEP, 32'h2);
    wk(6'h00, 1'h1, 3);
    chk_st(SSWC_S4, "event disabled");
    wr(`SSWC_ADDR_CTRL, 32'h2);
    wk(6'h00, 1'h1, 3);
    chk_st(SSWC_S0, "event wake");
    wr(`SSWC_ADDR_SLEEP, 32'h3);
    wk(6'h00, 1'h1, 3);
    chk_st(SSWC_S5, "event gated in off");
    wk(W_LAN, 1'h0, 3);
    chk_st(SSWC_S5, "network gated");
    wr(`SSWC_ADDR_CTRL, 32'h1);
    wk(W_LAN, 1'h0, 3);
    chk_st(SSWC_S0, "network wake");
    chk(cold, 1'h1, "cold boot");
    chk(warm, 1'h0, "no warm resume");
    $display("test event finished");
  endtask

  task automatic t_btn;
    wr(`SSWC_ADDR_CTRL, 32'h0);
    wk(W_BTN, 1'h0, 5);
    chk_st(SSWC_S1, "short to standby");
    wk(W_BTN, 1'h0, 5);
    chk_st(SSWC_S0, "short wake");
    wk(W_BTN, 1'h0, 30);
    chk_st(SSWC_S5, "long from on");
    wk(W_BTN, 1'h0, 5);
    chk_st(SSWC_S0, "short from off");
    wr(`SSWC_ADDR_CTRL, 32'h8);
    wk(W_BTN, 1'h0, 5);
    chk_st(SSWC_S3, "short to suspend");
    wk(W_BTN, 1'h0, 30);
    chk_st(SSWC_S5, "long from sleep");
    wk(W_BTN, 1'h0, 5);
    wr(`SSWC_ADDR_SLEEP, 32'h2);
    wk(W_BTN, 1'h0, 5);
    chk_st(SSWC_S0, "switch from hibernate");
    $display("test switch finished");
  endtask

  // Main sequence.
  initial begin
    t_reset;
    t_bus;
    t_s3s1;
    t_s4;
    t_pme_s5;
    t_btn;
    report_and_stop;
  end

  // Watchdog well beyond the several hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge core_clk);
    fail("watchdog");
    report_and_stop;
  end
endmodule

`default_nettype wire
